// ===== pkg/fps_defines.svh
`ifndef FPS_DEFINES_SVH
`define FPS_DEFINES_SVH

// Word-mode unlock addresses and command data
`define FPS_ADDR_UNLOCK1     21'h000555
`define FPS_ADDR_UNLOCK2     21'h0002AA
`define FPS_ADDR_ZERO        21'h000000
`define FPS_DATA_UNLOCK1     16'h00AA
`define FPS_DATA_UNLOCK2     16'h0055
`define FPS_DATA_ENTER_SEC   16'h0088
`define FPS_DATA_AUTOSEL     16'h0090
`define FPS_DATA_PROGRAM     16'h00A0
`define FPS_DATA_EXIT_SEC    16'h0000
`define FPS_DATA_RESET       16'h00F0

// Identification address bits (A0, A1) and sector field A20..A12
`define FPS_ID_A0_POS        0
`define FPS_ID_A1_POS        1
`define FPS_SECT_LSB         12
`define FPS_SECT_MSB         20
`define FPS_ADDR_LOCK_VERIFY 21'h000003
`define FPS_LOCK_BIT_POS     7

// Timing (ns) and clock rate
`define FPS_CLK_MHZ          10
`define FPS_T_WE_NS          100
`define FPS_T_ACC_NS         70
`define FPS_T_HV_SETUP_NS    4000
`define FPS_T_RP_NS          500
`define FPS_SYNC_STAGES      2
`define FPS_WE_CYC  ((`FPS_T_WE_NS * `FPS_CLK_MHZ + 999) / 1000)
`define FPS_RD_CYC  ((`FPS_T_ACC_NS * `FPS_CLK_MHZ + 999) / 1000 + `FPS_SYNC_STAGES)
`define FPS_HV_CYC  ((`FPS_T_HV_SETUP_NS * `FPS_CLK_MHZ + 999) / 1000)
`define FPS_RP_CYC  ((`FPS_T_RP_NS * `FPS_CLK_MHZ + 999) / 1000)

`endif

// ===== pkg/fps_pkg.sv
`default_nettype none
package fps_pkg;

   // Host operations
   typedef enum logic [2:0] {
      FPS_OP_READ    = 3'h0,
      FPS_OP_ID_HV   = 3'h1,
      FPS_OP_PROT_HV = 3'h2,
      FPS_OP_ENTER   = 3'h3,
      FPS_OP_EXIT    = 3'h4,
      FPS_OP_PROGRAM = 3'h5,
      FPS_OP_LOCKVER = 3'h6,
      FPS_OP_HWRESET = 3'h7
   } fps_op_t;

   // Sequencer states, Gray along IDLE-PREP-SETUP-STROBE-HOLD
   typedef enum logic [2:0] {
      FPS_ST_IDLE   = 3'h0,
      FPS_ST_PREP   = 3'h1,
      FPS_ST_SETUP  = 3'h3,
      FPS_ST_STROBE = 3'h2,
      FPS_ST_HOLD   = 3'h6,
      FPS_ST_DONE   = 3'h7
   } fps_state_t;

   // One bus cycle of a script
   typedef struct packed {
      logic        rd;
      logic        last;
      logic [20:0] addr;
      logic [15:0] data;
   } fps_step_t;

   // Whole module state
   typedef struct packed {
      fps_state_t  st;
      fps_op_t     op;
      logic [2:0]  idx;
      logic [7:0]  cnt;
      logic [20:0] arg_addr;
      logic [15:0] arg_data;
      logic [20:0] addr;
      logic [15:0] dq;
      logic        dq_oe;
      logic        ce_n;
      logic        oe_n;
      logic        we_n;
      logic        rst_n;
      logic        rst_hv;
      logic        a9_hv;
      logic        guard;
      logic [15:0] sync1;
      logic [15:0] sync2;
      logic [15:0] rdata;
      logic        done;
      logic        ready;
      logic        sec_mapped;
      logic        fac_locked;
   } fps_regs_t;

endpackage
`default_nettype wire

// ===== core/fps_host.sv
`include "fps_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module fps_host
   import fps_pkg::*;
#(
   parameter int WE_CYC = `FPS_WE_CYC,
   parameter int RD_CYC = `FPS_RD_CYC,
   parameter int HV_CYC = `FPS_HV_CYC,
   parameter int RP_CYC = `FPS_RP_CYC
) (
   input  wire logic        clock_in,
   input  wire logic        rst_n_in,
   input  wire logic        cmd_valid_in,
   input  wire logic [2:0]  cmd_op_in,
   input  wire logic [20:0] cmd_addr_in,
   input  wire logic [15:0] cmd_data_in,
   input  wire logic        temp_unprotect_in,
   input  wire logic        boot_guard_in,
   input  wire logic [15:0] flash_dq_in,
   output logic             cmd_ready_out,
   output logic             done_out,
   output logic [15:0]      rdata_out,
   output logic             sec_mapped_out,
   output logic             factory_locked_out,
   output logic [20:0]      flash_addr_out,
   output logic [15:0]      flash_dq_out,
   output logic             flash_dq_oe_out,
   output logic             flash_ce_n_out,
   output logic             flash_oe_n_out,
   output logic             flash_we_n_out,
   output logic             flash_reset_n_out,
   output logic             reset_hv_out,
   output logic             a9_hv_out,
   output logic             boot_guard_boost_pin_out
);

   fps_regs_t r_reg;
   fps_regs_t r_next;

   // Build one write step
   function automatic fps_step_t wr(input logic [20:0] a, input logic [15:0] d,
                                    input logic lst);
      fps_step_t s;
      s.rd   = 1'b0;
      s.last = lst;
      s.addr = a;
      s.data = d;
      return s;
   endfunction

   // Build one read step
   function automatic fps_step_t rd(input logic [20:0] a, input logic lst);
      fps_step_t s;
      s.rd   = 1'b1;
      s.last = lst;
      s.addr = a;
      s.data = 16'h0000;
      return s;
   endfunction

   // Bus cycle script per operation; full unlock prefix sent for ENTER, EXIT, PROGRAM and LOCKVER only
   function automatic fps_step_t step_of(input fps_op_t op, input logic [2:0] i,
                                         input logic [20:0] a, input logic [15:0] d);
      fps_step_t   s;
      logic [20:0] ida;
      ida = `FPS_ADDR_ZERO;
      s   = rd(a, 1'b1);
      case (op)
         FPS_OP_ID_HV: begin
            ida[`FPS_ID_A0_POS] = a[`FPS_ID_A0_POS];
            s = rd(ida, 1'b1);
         end
         FPS_OP_PROT_HV: begin
            ida[`FPS_ID_A1_POS] = 1'b1;
            ida[`FPS_SECT_MSB:`FPS_SECT_LSB] = a[`FPS_SECT_MSB:`FPS_SECT_LSB];
            s = rd(ida, 1'b1);
         end
         FPS_OP_READ: begin
            s = rd(a, 1'b1);
         end
         default: begin
            case (i)
               3'h0: s = wr(`FPS_ADDR_UNLOCK1, `FPS_DATA_UNLOCK1, 1'b0);
               3'h1: s = wr(`FPS_ADDR_UNLOCK2, `FPS_DATA_UNLOCK2, 1'b0);
               3'h2: begin
                  case (op)
                     FPS_OP_ENTER:   s = wr(`FPS_ADDR_UNLOCK1, `FPS_DATA_ENTER_SEC, 1'b1);
                     FPS_OP_PROGRAM: s = wr(`FPS_ADDR_UNLOCK1, `FPS_DATA_PROGRAM, 1'b0);
                     default:        s = wr(`FPS_ADDR_UNLOCK1, `FPS_DATA_AUTOSEL, 1'b0);
                  endcase
               end
               3'h3: begin
                  case (op)
                     FPS_OP_PROGRAM: s = wr(a, d, 1'b1);
                     FPS_OP_LOCKVER: s = rd(`FPS_ADDR_LOCK_VERIFY, 1'b0);
                     default:        s = wr(`FPS_ADDR_ZERO, `FPS_DATA_EXIT_SEC, 1'b1);
                  endcase
               end
               // Leave autoselect mode after lock verify
               default: s = wr(`FPS_ADDR_ZERO, `FPS_DATA_RESET, 1'b1);
            endcase
         end
      endcase
      return s;
   endfunction

   // Next-state logic
   always_comb begin
      fps_step_t s;
      r_next       = r_reg;
      s            = step_of(r_reg.op, r_reg.idx, r_reg.arg_addr, r_reg.arg_data);
      r_next.done  = 1'b0;
      // Pin data synchroniser, second stage alone is read
      r_next.sync1 = flash_dq_in;
      r_next.sync2 = r_reg.sync1;
      r_next.guard = boot_guard_in;
      case (r_reg.st)
         FPS_ST_IDLE: begin
            r_next.ready = 1'b1;
            if (cmd_valid_in) begin
               r_next.ready    = 1'b0;
               r_next.op       = fps_op_t'(cmd_op_in);
               r_next.arg_addr = cmd_addr_in;
               r_next.arg_data = cmd_data_in;
               r_next.idx      = 3'h0;
               r_next.cnt      = 8'h00;
               r_next.st       = FPS_ST_PREP;
            end
         end
         FPS_ST_PREP: begin
            // High voltage settle or reset pulse
            r_next.cnt = r_reg.cnt + 8'h01;
            if (r_reg.op == FPS_OP_HWRESET) begin
               r_next.rst_n = 1'b0;
               if (r_reg.cnt >= 8'(RP_CYC - 1)) begin
                  r_next.rst_n = 1'b1;
                  r_next.sec_mapped = 1'b0;
                  r_next.st = FPS_ST_DONE;
               end
            end else if (r_reg.op == FPS_OP_ID_HV || r_reg.op == FPS_OP_PROT_HV) begin
               r_next.a9_hv = 1'b1;
               if (r_reg.cnt >= 8'(HV_CYC - 1)) begin
                  r_next.st = FPS_ST_SETUP;
               end
            end else begin
               r_next.st = FPS_ST_SETUP;
            end
            if (r_next.st == FPS_ST_SETUP) begin
               r_next.cnt = 8'h00;
            end
         end
         FPS_ST_SETUP: begin
            // Address and data settle before strobe
            r_next.addr  = s.addr;
            r_next.dq    = s.data;
            r_next.dq_oe = ~s.rd;
            r_next.ce_n  = 1'b0;
            r_next.cnt   = 8'h00;
            r_next.st    = FPS_ST_STROBE;
         end
         FPS_ST_STROBE: begin
            r_next.cnt = r_reg.cnt + 8'h01;
            if (s.rd) begin
               r_next.oe_n = 1'b0;
               // Data reaches stage two only RD_CYC - 1 edges after OE falls, RD_CYC edges after strobe entry
               if (r_reg.cnt >= 8'(RD_CYC)) begin
                  r_next.rdata = r_reg.sync2;
                  if (r_reg.op == FPS_OP_LOCKVER) begin
                     r_next.fac_locked = r_reg.sync2[`FPS_LOCK_BIT_POS];
                  end
                  r_next.oe_n = 1'b1;
                  r_next.st   = FPS_ST_HOLD;
               end
            end else begin
               // OE held high while WE low
               r_next.oe_n = 1'b1;
               r_next.we_n = 1'b0;
               // Low for exactly WE_CYC cycles before release
               if (r_reg.cnt >= 8'(WE_CYC)) begin
                  r_next.we_n = 1'b1;
                  r_next.st   = FPS_ST_HOLD;
               end
            end
         end
         FPS_ST_HOLD: begin
            // Data held one cycle past strobe release
            r_next.ce_n  = 1'b1;
            r_next.dq_oe = 1'b0;
            r_next.idx   = r_reg.idx + 3'h1;
            r_next.st    = s.last ? FPS_ST_DONE : FPS_ST_SETUP;
         end
         FPS_ST_DONE: begin
            r_next.a9_hv = 1'b0;
            r_next.done  = 1'b1;
            if (r_reg.op == FPS_OP_ENTER) begin
               r_next.sec_mapped = 1'b1;
            end else if (r_reg.op == FPS_OP_EXIT) begin
               r_next.sec_mapped = 1'b0;
            end
            r_next.st = FPS_ST_IDLE;
         end
         default: begin
            r_next.st = FPS_ST_IDLE;
         end
      endcase
      // high voltage never during pin reset
      r_next.rst_hv = temp_unprotect_in & r_next.rst_n;
   end

   // State register; strobes idle high from reset on
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         r_reg            <= '0;
         r_reg.st         <= FPS_ST_IDLE;
         r_reg.op         <= FPS_OP_READ;
         r_reg.ce_n       <= 1'b1;
         r_reg.oe_n       <= 1'b1;
         r_reg.we_n       <= 1'b1;
         r_reg.rst_n      <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // Outputs straight from the state register
   assign cmd_ready_out            = r_reg.ready;
   assign done_out                 = r_reg.done;
   assign rdata_out                = r_reg.rdata;
   assign sec_mapped_out           = r_reg.sec_mapped;
   assign factory_locked_out       = r_reg.fac_locked;
   assign flash_addr_out           = r_reg.addr;
   assign flash_dq_out             = r_reg.dq;
   assign flash_dq_oe_out          = r_reg.dq_oe;
   assign flash_ce_n_out           = r_reg.ce_n;
   assign flash_oe_n_out           = r_reg.oe_n;
   assign flash_we_n_out           = r_reg.we_n;
   assign flash_reset_n_out        = r_reg.rst_n;
   assign reset_hv_out             = r_reg.rst_hv;
   assign a9_hv_out                = r_reg.a9_hv;
   assign boot_guard_boost_pin_out = r_reg.guard;

endmodule
`default_nettype wire

// ===== bench/fps_host_props.sv
`timescale 1ns/100ps
`default_nettype none
module fps_host_props (
   input wire logic        clock_in,
   input wire logic        rst_n_in,
   input wire logic        cmd_valid_in,
   input wire logic [2:0]  cmd_op_in,
   input wire logic [20:0] cmd_addr_in,
   input wire logic [15:0] cmd_data_in,
   input wire logic        temp_unprotect_in,
   input wire logic        boot_guard_in,
   input wire logic [15:0] flash_dq_in,
   input wire logic        cmd_ready_out,
   input wire logic        done_out,
   input wire logic [15:0] rdata_out,
   input wire logic        sec_mapped_out,
   input wire logic        factory_locked_out,
   input wire logic [20:0] flash_addr_out,
   input wire logic [15:0] flash_dq_out,
   input wire logic        flash_dq_oe_out,
   input wire logic        flash_ce_n_out,
   input wire logic        flash_oe_n_out,
   input wire logic        flash_we_n_out,
   input wire logic        flash_reset_n_out,
   input wire logic        reset_hv_out,
   input wire logic        a9_hv_out,
   input wire logic        boot_guard_boost_pin_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   chk_write_qual: assert property (!flash_we_n_out |-> !flash_ce_n_out && flash_oe_n_out && flash_dq_oe_out)
      else $error("write strobe without qualifiers");
   // Strobe is one cycle wide with the default width
   chk_strobe_width: assert property ($fell(flash_we_n_out) |=> flash_we_n_out)
      else $error("write strobe width wrong");
   chk_guard_level: assert property ($past(rst_n_in) |-> boot_guard_boost_pin_out == $past(boot_guard_in))
      else $error("guard pin not following request");
   chk_hv_reset: assert property (reset_hv_out |-> flash_reset_n_out)
      else $error("high voltage on a low reset pin");
   chk_id_pins: assert property (a9_hv_out && !flash_oe_n_out |-> !flash_ce_n_out && flash_we_n_out && !flash_addr_out[6] && !(flash_addr_out[1] && flash_addr_out[0]))
      else $error("identification read pins wrong");
   chk_hv_settle: assert property ($rose(a9_hv_out) |-> flash_oe_n_out [*3])
      else $error("read before high voltage settles");
   chk_ready_drop: assert property (cmd_ready_out && cmd_valid_in |=> !cmd_ready_out && !done_out)
      else $error("ready held after acceptance");
   chk_done_ready: assert property (done_out |=> cmd_ready_out)
      else $error("not ready after done");
   chk_map_enter: assert property ($rose(sec_mapped_out) |-> done_out || $past(done_out))
      else $error("mapping set outside completion");
   chk_map_reset: assert property (!flash_reset_n_out |-> ##[0:20] !sec_mapped_out)
      else $error("mapping kept over hardware reset");
endmodule
bind fps_host fps_host_props u_props (.*);
`default_nettype wire

// ===== bench/fps_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module fps_flash_model #(
   parameter logic [15:0] MAKER     = 16'h005A, // Arbitrary value
   parameter logic [15:0] DEVID     = 16'h1234, // Arbitrary value
   parameter logic [15:0] SERIAL    = 16'h3C00, // Arbitrary value
   parameter logic [8:0]  PROT_SECT = 9'h001,
   parameter bit          FACTORY   = 1'b0
) (
   input  wire logic [20:0] addr_in,
   input  wire logic [15:0] dq_in,
   input  wire logic        ce_n_in,
   input  wire logic        oe_n_in,
   input  wire logic        we_n_in,
   input  wire logic        reset_n_in,
   input  wire logic        reset_hv_in,
   input  wire logic        a9_hv_in,
   input  wire logic        guard_in,
   output logic [15:0]      dq_out
);
   logic [15:0] mem [0:255];
   logic [15:0] sec [0:255];
   logic [15:0] rd, last;
   logic [1:0]  step;
   logic        mapped, autosel, boot, hit;
   // bottom boot, two lowest 8 KB sectors
   assign boot = (addr_in[20:13] == 8'h00);
   assign hit = mapped && boot;
   initial begin
      foreach (mem[i]) mem[i] = 16'hFFFF;
      foreach (sec[i]) sec[i] = 16'hFFFF;
      // serial words at the region base
      for (int i = 0; i < 8; i++) sec[i] = SERIAL ^ 16'(i);
      step = 2'h0;
      mapped = 1'b0;
      autosel = 1'b0;
      last = 16'h0000;
   end
   always @(negedge reset_n_in) begin
      step = 2'h0;
      mapped = 1'b0;
      autosel = 1'b0;
   end
   always @(posedge we_n_in) begin
      if (!ce_n_in && oe_n_in && reset_n_in) begin
         if (autosel && dq_in[7:0] == 8'h00) begin
            mapped = 1'b0;
            autosel = 1'b0;
         end else if (dq_in[7:0] == 8'hF0) begin
            autosel = 1'b0;
            step = 2'h0;
         end else if (step == 2'h3) begin
            step = 2'h0;
            if (hit) begin
               if (!FACTORY) sec[addr_in[7:0]] = dq_in;
            end else if (!(boot && !guard_in) && !(addr_in[20:12] == PROT_SECT && !reset_hv_in))
               mem[addr_in[7:0]] = dq_in;
         end else if (step == 2'h2 && addr_in[11:0] == 12'h555) begin
            step = (dq_in[7:0] == 8'hA0) ? 2'h3 : 2'h0;
            if (dq_in[7:0] == 8'h88) mapped = 1'b1;
            if (dq_in[7:0] == 8'h90) autosel = 1'b1;
         end else if (step == 2'h1 && addr_in[11:0] == 12'h2AA && dq_in[7:0] == 8'h55)
            step = 2'h2;
         else
            step = (addr_in[11:0] == 12'h555 && dq_in[7:0] == 8'hAA) ? 2'h1 : 2'h0;
      end
   end
   always_comb begin
      if (a9_hv_in) rd = addr_in[1] ? {15'h0000, addr_in[20:12] == PROT_SECT} :
                         (addr_in[0] ? DEVID : MAKER);
      else if (autosel && addr_in[1:0] == 2'h3) rd = FACTORY ? 16'h0099 : 16'h0019;
      else if (hit) rd = sec[addr_in[7:0]];
      else rd = mem[addr_in[7:0]];
   end
   // Released bus shows the inverse, so a stale capture fails
   always @* if (!ce_n_in && !oe_n_in) last = rd;
   assign dq_out = (!ce_n_in && !oe_n_in) ? rd : ~last;
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top import fps_pkg::*;;
   localparam logic [15:0] MAKER = 16'h005A; // Arbitrary value
   localparam logic [15:0] DEVID = 16'h1234; // Arbitrary value
   localparam logic [15:0] SERIAL = 16'h3C00; // Arbitrary value
   logic clk, rst_n, valid, tun, guard, ready, done, smap, flock, foe, ce_n, oe_n, we_n;
   logic frst_n, rhv, a9hv, wp;
   logic [2:0]  op;
   logic [20:0] addr, fa, a;
   logic [15:0] wd, rdata, fdi, fdo;
   logic [31:0] r;
   int n_errors, n_tests, seed;
   fps_host #(.HV_CYC(4), .RP_CYC(2)) dut (.clock_in(clk), .rst_n_in(rst_n),
      .cmd_valid_in(valid), .cmd_op_in(op), .cmd_addr_in(addr), .cmd_data_in(wd),
      .temp_unprotect_in(tun), .boot_guard_in(guard), .flash_dq_in(fdi),
      .cmd_ready_out(ready), .done_out(done), .rdata_out(rdata), .sec_mapped_out(smap),
      .factory_locked_out(flock), .flash_addr_out(fa), .flash_dq_out(fdo),
      .flash_dq_oe_out(foe), .flash_ce_n_out(ce_n), .flash_oe_n_out(oe_n),
      .flash_we_n_out(we_n), .flash_reset_n_out(frst_n), .reset_hv_out(rhv),
      .a9_hv_out(a9hv), .boot_guard_boost_pin_out(wp));
   fps_flash_model #(.MAKER(MAKER), .DEVID(DEVID), .SERIAL(SERIAL)) flash (.addr_in(fa),
      .dq_in(fdo),
      .ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n), .reset_n_in(frst_n),
      .reset_hv_in(rhv), .a9_hv_in(a9hv), .guard_in(wp), .dq_out(fdi));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic finish_test();
      $display("errors %0d comparisons %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   // One operation: wait for ready, hold the request over the taking edge,
   // then wait for done; sampled at falling edges, clear of the launch edge
   task automatic run(input logic [2:0] o, input logic [20:0] ad, input logic [15:0] d);
      int k;
      k = 0;
      while (ready !== 1'b1 && k < 50) begin
         @(negedge clk);
         k++;
      end
      op = o;
      addr = ad;
      wd = d;
      valid = 1'b1;
      @(negedge clk);
      valid = 1'b0;
      do begin
         @(negedge clk);
         k++;
      end while (done !== 1'b1 && k < 350);
      if (k >= 350) begin
         n_errors++;
         finish_test();
      end
   endtask
   // Word left after a program, from guard, unprotect and sector
   function automatic logic [15:0] exp_prog(input logic [20:0] ad, input logic g,
                                            input logic t, input logic [15:0] d);
      if (ad[20:13] == 8'h00 && !g) return 16'hFFFF;
      if (ad[20:12] == 9'h001 && !t) return 16'hFFFF;
      return d;
   endfunction
   initial begin
      seed = 32'h731A4332;
      {rst_n, valid, tun} = 3'h0;
      guard = 1'b1;
      op = 3'h0;
      addr = 21'h000000;
      wd = 16'h0000;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      run(FPS_OP_ID_HV, 21'h000000, 16'h0000); chk(MAKER, rdata);
      run(FPS_OP_ID_HV, 21'h000001, 16'h0000); chk(DEVID, rdata);
      run(FPS_OP_PROT_HV, 21'h001000, 16'h0000); chk(16'h0001, rdata);
      run(FPS_OP_PROT_HV, 21'h101000, 16'h0000); chk(16'h0000, rdata);
      // Guard low beats temporary unprotect
      guard = 1'b0;
      tun = 1'b1;
      run(FPS_OP_PROGRAM, 21'h0010F0, 16'h1357);
      run(FPS_OP_READ, 21'h0010F0, 16'h0000); chk(16'hFFFF, rdata);
      // Random program and read-back over boot and plain sectors
      for (int i = 0; i < 24; i++) begin
         r = $random(seed);
         a = {7'h00, r[1:0], 4'h0, i[7:0]};
         guard = r[4];
         tun = r[5];
         run(FPS_OP_PROGRAM, a, r[31:16]);
         run(FPS_OP_READ, a, 16'h0000);
         chk(exp_prog(a, r[4], r[5], r[31:16]), rdata);
      end
      guard = 1'b1;
      tun = 1'b0;
      run(FPS_OP_LOCKVER, 21'h000000, 16'h0000); chk(16'h0019, rdata);
      chk(16'h0000, {15'h0000, flock});
      run(FPS_OP_ENTER, 21'h000000, 16'h0000); chk(16'h0001, {15'h0000, smap});
      run(FPS_OP_READ, 21'h000003, 16'h0000); chk(SERIAL ^ 16'h0003, rdata);
      run(FPS_OP_PROGRAM, 21'h000020, 16'hA5C3);
      run(FPS_OP_READ, 21'h000020, 16'h0000); chk(16'hA5C3, rdata);
      run(FPS_OP_EXIT, 21'h000000, 16'h0000); chk(16'h0000, {15'h0000, smap});
      run(FPS_OP_READ, 21'h000020, 16'h0000); chk(16'hFFFF, rdata);
      run(FPS_OP_ENTER, 21'h000000, 16'h0000);
      // Unprotect request held over the reset pulse
      tun = 1'b1;
      run(FPS_OP_HWRESET, 21'h000000, 16'h0000); chk(16'h0000, {15'h0000, smap});
      tun = 1'b0;
      run(FPS_OP_READ, 21'h000020, 16'h0000); chk(16'hFFFF, rdata);
      finish_test();
   end
   // Watchdog far beyond the expected run length
   initial begin
      #2000000;
      n_errors++;
      finish_test();
   end
endmodule
`default_nettype wire
